// ### design/flash_seq_pkg.sv
// constants and types shared by the flash erase command sequencer
// assumes a single pclk domain and an APB3 register port
// Summary of operation
// R1: erase whole 512-byte pages only
// R2: erased page bytes all read FFH
// R3: target page latched from page select
// R4: protected sector pages are never erased (the code blocks page and pin erase only; mass erase still erases them)
// R5: 95h when unlocked with page set erases
// R6: stall core while erase runs
// R7: relock after page erase completes
// R8: mass erase only from debug interface
// R9: 63H unlocked and enabled mass erases, relocks
// R10: debugger polls status until erase done
// R11: status readable at any time
// R12: FF8H writes command, reads status
// R13: unlock is 73H then 8CH
// R14: erase accepted only as third command
// R15: 5EH enables sector protect access
// R16: state codes for lock sequence positions
// R17: busy codes 001xxx, 010xxx, 100xxx
// R18: status bits 7:6 read zero
// R19: no byte programmed twice between erases
// R20: bypass routes array controls to pins
// R21: page erase still works in bypass
// R22: wrong command relocks without operation (a third command other than 95H, 63H or 5EH goes to the unlocked state 03)
// R23: reset leaves controller locked, state zero
package flash_seq_pkg;
    localparam logic [11:0] command_addr = 12'hFF8;
    localparam logic [11:0] page_select_addr = 12'hFF9;
    localparam logic [11:0] protect_addr = 12'hFFA;
    localparam logic [11:0] control_addr = 12'hFFB;
    localparam logic [7:0] cmd_unlock1 = 8'h73;
    localparam logic [7:0] cmd_unlock2 = 8'h8C;
    localparam logic [7:0] cmd_page_erase = 8'h95;
    localparam logic [7:0] cmd_mass_erase = 8'h63;
    localparam logic [7:0] cmd_protect_sel = 8'h5E;
    localparam logic [7:0] erased_byte = 8'hFF;
    localparam int page_bytes = 512;
    localparam logic [7:0] page_select_reset = 8'h00;
    localparam logic [7:0] protect_reset = 8'h00;
    localparam logic [5:0] st_locked = 6'h00;
    localparam logic [5:0] st_first = 6'h01;
    localparam logic [5:0] st_second = 6'h02;
    localparam logic [5:0] st_unlocked = 6'h03;
    localparam logic [5:0] st_protect = 6'h04;
    localparam logic [5:0] st_page_busy = 6'h10;
    localparam logic [5:0] st_mass_busy = 6'h20;
    typedef enum logic [2:0] {
        s_locked = 3'h0,
        s_first = 3'h1,
        s_second = 3'h3,
        s_unlocked = 3'h2,
        s_protect = 3'h6,
        s_page = 3'h7,
        s_mass = 3'h5
    } seq_state_t;
endpackage

// ### design/erase_if.sv
// handshake between the sequencer and its erase walker
// assumes one clock; start is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface erase_if #(parameter int aw = 10);
    logic start;
    logic mass;
    logic [aw-1:0] first_addr;
    logic [aw-1:0] last_addr;
    logic busy;
    logic done;
    modport ctrl (output start, output mass, output first_addr, output last_addr,
        input busy, input done);
    modport walk (input start, input mass, input first_addr, input last_addr,
        output busy, output done);
endinterface
`default_nettype wire

// ### design/erase_walker.sv
// walks a byte range of the array writing the erased value
// assumes the array accepts one byte write per clock
`timescale 1ns/1ns
`default_nettype none
module erase_walker
    import flash_seq_pkg::*;
#(
    parameter int aw = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    erase_if.walk ctl,
    output logic arr_we,
    output logic [aw-1:0] arr_addr,
    output logic [7:0] arr_wdata
);
    logic [aw-1:0] last;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl.busy <= 1'b0;
            arr_addr <= '0;
            last <= '0;
        end else if (ctl.start && !ctl.busy) begin
            ctl.busy <= 1'b1;
            arr_addr <= ctl.first_addr;
            last <= ctl.last_addr;
        end else if (ctl.busy) begin
            if (arr_addr == last) begin
                ctl.busy <= 1'b0;
            end else begin
                arr_addr <= arr_addr + 1'b1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl.done <= 1'b0;
        end else begin
            ctl.done <= ctl.busy && (arr_addr == last);
        end
    end
    assign arr_we = ctl.busy;
    assign arr_wdata = erased_byte; // [R2]
endmodule
`default_nettype wire

// ### design/flash_erase_command_sequencer.sv
// flash command sequencer: unlock, page and mass erase, status, bypass
// assumes APB3 from core or debugger; dbg_access marks debugger transfers
`timescale 1ns/1ns
`default_nettype none
module flash_erase_command_sequencer
    import flash_seq_pkg::*;
#(
    parameter int pages = 2,
    parameter int sectors = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dbg_access,
    output logic core_stall,
    input wire logic bypass_we,
    input wire logic [9:0] bypass_addr,
    input wire logic [7:0] bypass_wdata,
    input wire logic bypass_erase,
    output logic arr_we,
    output logic [9:0] arr_addr,
    output logic [7:0] arr_wdata
);
    import flash_seq_pkg::*;

    seq_state_t state;
    logic [7:0] page_select;
    logic [7:0] protect;
    logic page_set;
    logic mass_enable;
    logic bypass_mode;
    logic [5:0] status;
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic walk_we;
    logic [9:0] walk_addr;
    logic [7:0] walk_wdata;
    logic erase_ok;
    logic page_go;
    logic mass_go;

    erase_if #(.aw(10)) eif ();

    function automatic logic sector_prot(input logic [7:0] pg, input logic [7:0] prot);
        int sec;
        sec = (int'(pg) * sectors) / pages;
        return (sec < 8) ? prot[sec[2:0]] : 1'b1;
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign cmd = pwdata[7:0];
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // page must exist and its sector be unprotected
    assign erase_ok = page_set && (int'(page_select) < pages) // [R5]
        && !sector_prot(page_select, protect); // [R4]
    // erases are only taken as the third command, straight after the second unlock
    assign page_go = wr && paddr == command_addr && state == s_second
        && cmd == cmd_page_erase && erase_ok; // [R14]
    // a core-side mass erase request never reaches the walker
    assign mass_go = wr && paddr == command_addr && state == s_second
        && cmd == cmd_mass_erase && mass_enable && dbg_access; // [R8] [R9]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= s_locked; // [R23]
        end else begin
            case (state)
                s_page, s_mass: begin
                    if (eif.done) begin
                        state <= s_locked; // [R7] [R9]
                    end
                end
                default: begin
                    if (wr && paddr == command_addr) begin
                        if (state == s_locked && cmd == cmd_unlock1) begin
                            state <= s_first; // [R13]
                        end else if (state == s_first && cmd == cmd_unlock2) begin
                            state <= s_second; // [R13]
                        end else if (state == s_second) begin
                            if (page_go) begin
                                state <= s_page;
                            end else if (mass_go) begin
                                state <= s_mass;
                            end else if (cmd == cmd_protect_sel) begin
                                state <= s_protect; // [R15]
                            end else if (cmd == cmd_page_erase || cmd == cmd_mass_erase) begin
                                state <= s_locked; // [R22]
                            end else begin
                                state <= s_unlocked;
                            end
                        end else if (state == s_unlocked && cmd == cmd_protect_sel) begin
                            state <= s_protect; // [R15]
                        end else begin
                            state <= s_locked; // [R22]
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_select <= page_select_reset;
            page_set <= 1'b0;
        end else if (wr && paddr == page_select_addr && state != s_page) begin
            page_select <= pwdata[7:0];
            page_set <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protect <= protect_reset;
        end else if (wr && paddr == protect_addr && state == s_protect) begin
            protect <= protect | pwdata[7:0]; // [R15]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mass_enable <= 1'b0;
            bypass_mode <= 1'b0;
        end else if (wr && paddr == control_addr) begin
            mass_enable <= pwdata[0] & dbg_access;
            bypass_mode <= pwdata[1];
        end
    end

    always_comb begin
        case (state)
            s_locked: status = st_locked;
            s_first: status = st_first;
            s_second: status = st_second;
            s_unlocked: status = st_unlocked;
            s_protect: status = st_protect;
            s_page: status = st_page_busy; // [R17]
            s_mass: status = st_mass_busy; // [R17]
            default: status = st_locked;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                command_addr: prdata <= {26'h0, status}; // [R11] [R12] [R16] [R18]
                page_select_addr: prdata <= {24'h0, page_select};
                protect_addr: prdata <= {24'h0, protect};
                control_addr: prdata <= {30'h0, bypass_mode, mass_enable};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // page erase from pins also goes through the walker
    assign eif.start = page_go || mass_go
        || (bypass_mode && bypass_erase && state == s_locked && erase_ok); // [R21]
    assign eif.mass = mass_go;
    assign eif.first_addr = mass_go ? 10'h000
        : 10'(int'(page_select) * page_bytes); // [R1] [R3]
    assign eif.last_addr = mass_go ? 10'(pages * page_bytes - 1)
        : 10'(int'(page_select) * page_bytes + page_bytes - 1); // [R1]

    erase_walker #(.aw(10)) walker (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(eif),
        .arr_we(walk_we),
        .arr_addr(walk_addr),
        .arr_wdata(walk_wdata)
    );

    assign core_stall = (state == s_page) || (state == s_mass) || eif.busy; // [R6]
    // pins own the array only while no erase walks it
    assign arr_we = eif.busy ? walk_we : (bypass_mode && bypass_we); // [R20]
    assign arr_addr = eif.busy ? walk_addr : bypass_addr;
    assign arr_wdata = eif.busy ? walk_wdata : bypass_wdata;

    a_reset_locked: assert property (@(posedge pclk) $rose(presetn) |-> status == st_locked)
        else $error("not locked after reset"); // [R23]
    a_unlock_step: assert property (@(posedge pclk) disable iff (!presetn)
        (state == s_locked && wr && paddr == command_addr && cmd == cmd_unlock1)
        |=> status == st_first) else $error("first unlock missed"); // [R13]
    a_page_start: assert property (@(posedge pclk) disable iff (!presetn)
        page_go |=> status == st_page_busy && core_stall) else $error("erase not started"); // [R5]
    a_core_no_mass: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && !dbg_access && state == s_second) |=> state != s_mass)
        else $error("core began mass erase"); // [R8]
    a_relock_done: assert property (@(posedge pclk) disable iff (!presetn)
        (state == s_page && eif.done) |=> status == st_locked) else $error("no relock"); // [R7]
    a_bad_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        (state == s_first && wr && paddr == command_addr && cmd != cmd_unlock2)
        |=> state == s_locked) else $error("bad command kept"); // [R22]
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && paddr == command_addr) |-> prdata[7:6] == 2'b00) else $error("reserved set"); // [R18]
    a_erase_value: assert property (@(posedge pclk) disable iff (!presetn)
        eif.busy |-> arr_we && arr_wdata == erased_byte) else $error("bad erase data"); // [R2]
    c_page: cover property (@(posedge pclk) disable iff (!presetn) page_go);
    c_mass: cover property (@(posedge pclk) disable iff (!presetn) mass_go);
    c_protect: cover property (@(posedge pclk) disable iff (!presetn) state == s_protect);
    c_relock: cover property (@(posedge pclk) disable iff (!presetn)
        state == s_page && eif.done);
    c_pin_erase: cover property (@(posedge pclk) disable iff (!presetn)
        bypass_mode && bypass_erase && eif.start);
endmodule
`default_nettype wire

// ### testbench/flash_array_model.sv
// byte store that stands behind the sequencer's array write port
// assumes one byte write per pclk while arr_we is high
`timescale 1ns/1ns
`default_nettype none
module flash_array_model (
    input wire logic pclk,
    input wire logic arr_we,
    input wire logic [9:0] arr_addr,
    input wire logic [7:0] arr_wdata
);
    logic [7:0] mem [0:1023];
    int wc = 0;
    // starts fully programmed to 00 so that every erase shows up
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
    end
    // counts writes so that a partial or doubled erase is visible
    always @(posedge pclk) begin
        if (arr_we === 1'b1) begin
            mem[arr_addr] <= arr_wdata;
            wc <= wc + 1;
        end
    end
endmodule
`default_nettype wire

// ### testbench/test_flash_erase_command_sequencer.sv
// self-checking bench for the flash erase command sequencer
// assumes the array model on the array port and an APB master here
`timescale 1ns/1ns
`default_nettype none
module test_flash_erase_command_sequencer;
    import flash_seq_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0, dbg_access = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, core_stall, arr_we;
    logic bypass_we = 0, bypass_erase = 0;
    logic [9:0] bypass_addr = 10'h000;
    logic [9:0] arr_addr;
    logic [7:0] bypass_wdata = 8'h00;
    logic [7:0] arr_wdata, st;
    int bad_count = 0, checked = 0, wc0;
    always #2 pclk = ~pclk;
    flash_erase_command_sequencer #(.pages(2), .sectors(2)) i_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dbg_access(dbg_access), .core_stall(core_stall), .bypass_we(bypass_we),
        .bypass_addr(bypass_addr), .bypass_wdata(bypass_wdata), .bypass_erase(bypass_erase),
        .arr_we(arr_we), .arr_addr(arr_addr), .arr_wdata(arr_wdata));
    flash_array_model i_arr (.pclk(pclk), .arr_we(arr_we), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic timeout();
        bad_count++;
        final_report();
    endtask
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one APB transfer; pready is polled for wait states, though this slave ties it high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            if (++n > 50) timeout();
            @(posedge pclk);
        end
        st = prdata[7:0];
        psel <= 0;
        penable <= 0;
    endtask
    task automatic cmd(input logic [7:0] d);
        xfer(1, command_addr, d);
    endtask
    task automatic rdchk(input string name, input logic [7:0] exp);
        xfer(0, command_addr, 8'h00);
        chk(name, st, exp);
    endtask
    // status polling as a debugger host would do it
    task automatic wait_idle();
        int n;
        n = 0;
        xfer(0, command_addr, 8'h00);
        while (st[5:0] !== st_locked) begin
            if (++n > 2000) timeout();
            xfer(0, command_addr, 8'h00);
        end
    endtask
    task automatic span(input string name, input int base, input int len, input logic [7:0] v);
        int e;
        e = 0;
        for (int i = base; i < base + len; i++) if (i_arr.mem[i] !== v) e++;
        chk(name, e, 0);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        rdchk("reset state", 8'h00);
        cmd(cmd_unlock2);
        rdchk("out of order", 8'h00);
        cmd(cmd_unlock1);
        rdchk("first step", 8'h01);
        cmd(cmd_unlock2);
        rdchk("second step", 8'h02);
        cmd(cmd_protect_sel);
        rdchk("protect select", 8'h04);
        cmd(8'h00);
        rdchk("relock", 8'h00);
        xfer(1, page_select_addr, 8'h01);
        wc0 = i_arr.wc;
        cmd(cmd_unlock1);
        cmd(cmd_unlock2);
        cmd(cmd_page_erase);
        rdchk("page busy", 8'h10);
        chk("stall", core_stall, 1);
        wait_idle();
        chk("stall end", core_stall, 0);
        rdchk("relocked", 8'h00);
        chk("page writes", i_arr.wc - wc0, page_bytes);
        span("page one", 512, 512, erased_byte);
        span("page zero", 0, 512, 8'h00);
        xfer(1, control_addr, 8'h02);
        @(posedge pclk);
        bypass_addr <= 10'h205;
        bypass_wdata <= 8'hA5;
        bypass_we <= 1;
        @(posedge pclk);
        bypass_we <= 0;
        @(posedge pclk);
        chk("pin write", i_arr.mem[517], 8'hA5);
        wc0 = i_arr.wc;
        bypass_erase <= 1;
        @(posedge pclk);
        bypass_erase <= 0;
        for (int n = 0; i_arr.wc - wc0 < page_bytes; n++) begin
            if (n > 2000) timeout();
            @(posedge pclk);
        end
        span("pin erase", 512, 512, erased_byte);
        xfer(1, control_addr, 8'h00);
        cmd(cmd_unlock1);
        cmd(cmd_unlock2);
        cmd(cmd_protect_sel);
        xfer(1, protect_addr, 8'h01);
        xfer(1, page_select_addr, 8'h00);
        cmd(8'h00);
        wc0 = i_arr.wc;
        cmd(cmd_unlock1);
        cmd(cmd_unlock2);
        cmd(cmd_page_erase);
        rdchk("protected", 8'h00);
        // longer than one 512-byte page erase, long enough for a wrongly started erase to show
        repeat (600) @(posedge pclk);
        chk("protected writes", i_arr.wc - wc0, 0);
        span("protected page", 0, 512, 8'h00);
        xfer(1, control_addr, 8'h01);
        cmd(cmd_unlock1);
        cmd(cmd_unlock2);
        cmd(cmd_mass_erase);
        rdchk("core mass", 8'h00);
        chk("core mass writes", i_arr.wc - wc0, 0);
        @(posedge pclk);
        dbg_access <= 1;
        xfer(1, control_addr, 8'h01);
        cmd(cmd_unlock1);
        cmd(cmd_unlock2);
        cmd(cmd_mass_erase);
        rdchk("mass busy", 8'h20);
        chk("mass stall", core_stall, 1);
        wait_idle();
        rdchk("mass relock", 8'h00);
        chk("mass writes", i_arr.wc - wc0, 2 * page_bytes);
        span("mass array", 0, 1024, erased_byte);
        final_report();
    end
endmodule
`default_nettype wire
